// ### verilog/ftm_pkg.sv
package ftm_pkg;
	localparam int NCH = 6;
	localparam int EXT_CH = 2;
	// Register map, byte addresses; channel n sits at n * CH_STRIDE
	localparam logic [7:0] CH_STRIDE = 8'h20;
	localparam logic [4:0] OFF_CTRL = 5'h00;
	localparam logic [4:0] OFF_STAT = 5'h04;
	localparam logic [4:0] OFF_CNT = 5'h08;
	localparam logic [4:0] OFF_RLD = 5'h0c;
	localparam logic [4:0] OFF_CMP = 5'h10;
	localparam logic [4:0] OFF_LVL = 5'h14;
	localparam logic [4:0] OFF_OUT = 5'h18;
	localparam logic [7:0] OFF_START = 8'hc0;
	localparam logic [7:0] OFF_STOP = 8'hc4;
	// Field positions
	localparam int CTRL_CLK_LSB = 0;
	localparam int CTRL_MOD_LSB = 3;
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_EVT_BIT = 1;
	// Reset values and the counter maximum
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	// Operating modes
	localparam logic [1:0] MODE_ART = 2'b00;
	localparam logic [1:0] MODE_CMO = 2'b01;
	localparam logic [1:0] MODE_PWM = 2'b10;
	localparam logic [1:0] MODE_CAP = 2'b11;
	// Level codes
	localparam logic [1:0] LV_LOW = 2'b00;
	localparam logic [1:0] LV_HIGH = 2'b01;
	localparam logic [1:0] LV_TOGGLE = 2'b10;
	localparam logic [1:0] CAP_RISE = 2'b01;
	localparam logic [1:0] CAP_FALL = 2'b10;
	// Count clock selections and bus response codes
	localparam logic [2:0] CLK_SYS = 3'h0;
	localparam logic [2:0] CLK_EXT_RISE = 3'h6;
	localparam logic [2:0] CLK_EXT_FALL = 3'h7;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] clk_sel;
		logic ovf_flag;
		logic evt_flag;
		logic [15:0] cnt;
		logic [15:0] rld;
		logic [15:0] cmp;
		logic [1:0] lvl;
		logic out;
	} chan_t;

	typedef struct packed {
		chan_t [NCH-1:0] ch;
		logic [NCH-1:0] en;
		logic [NCH-1:0] ovf_irq;
		logic [NCH-1:0] evt_irq;
		logic [NCH-1:0] out_oe;
		logic [NCH-1:0] cap_s1;
		logic [NCH-1:0] cap_s2;
		logic [NCH-1:0] cap_s3;
		logic [EXT_CH-1:0] xclk_s1;
		logic [EXT_CH-1:0] xclk_s2;
		logic [EXT_CH-1:0] xclk_s3;
		logic [6:0] pre;
		logic aw_full;
		logic [7:0] aw_addr;
		logic w_full;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_t;
endpackage

// ### verilog/flexible_timer.sv
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module flexible_timer (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [5:0] capture_input_pin,
	input wire logic [1:0] timer_clock_pin,
	output logic [5:0] timer_output_pin,
	output logic [5:0] timer_output_oe,
	output logic [5:0] overflow_irq,
	output logic [5:0] event_irq
);
	ftm_pkg::state_t s_ff;
	ftm_pkg::state_t nxt_s;
	logic [5:0] tick;
	logic [5:0] cap_hit;
	logic [5:0] xrise;
	logic [5:0] xfall;
	logic wr_go;
	logic [7:0] wr_a;
	logic [31:0] wr_d;
	logic [31:0] rd_word;
	logic [2:0] wr_k;

	// Count enables: divide by 2**sel, except sel 6/7 on channels 0-1 take the external clock edges; one-cycle pulses
	function automatic logic tick_sel(input int idx, input logic [2:0] sel,
		input logic [6:0] pre, input logic rise, input logic fall);
		logic t;
		logic [6:0] mask;
		t = 1'b0;
		mask = 7'((8'h01 << sel) - 8'h01);
		if (sel == ftm_pkg::CLK_SYS) begin
			t = 1'b1;
		end else if (idx < ftm_pkg::EXT_CH && sel == ftm_pkg::CLK_EXT_RISE) begin
			t = rise;
		end else if (idx < ftm_pkg::EXT_CH && sel == ftm_pkg::CLK_EXT_FALL) begin
			t = fall;
		end else begin
			t = &(pre | ~mask);
		end
		return t;
	endfunction

	// Decode shared by the read and write paths
	function automatic logic addr_ok(input logic [7:0] a);
		logic ok;
		ok = 1'b0;
		if (a[1:0] == 2'b00) begin
			if (a == ftm_pkg::OFF_START || a == ftm_pkg::OFF_STOP) begin
				ok = 1'b1;
			end else if (a[7:5] < 3'h6 && a[4:0] <= ftm_pkg::OFF_OUT) begin
				ok = 1'b1;
			end
		end
		return ok;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] d, input logic [1:0] strb);
		logic [15:0] m;
		m = old;
		if (strb[0]) begin
			m[7:0] = d[7:0];
		end
		if (strb[1]) begin
			m[15:8] = d[15:8];
		end
		return m;
	endfunction

	assign wr_go = s_ff.aw_full && s_ff.w_full && !s_ff.bvalid;
	assign wr_a = s_ff.aw_addr;
	assign wr_d = s_ff.w_data;
	assign wr_k = wr_a[7:5];

	always_comb begin
		ftm_pkg::chan_t c;
		c = '0;
		nxt_s = s_ff;
		rd_word = 32'h0000_0000;
		nxt_s.pre = s_ff.pre + 7'h01;
		nxt_s.cap_s1 = capture_input_pin;
		nxt_s.cap_s2 = s_ff.cap_s1;
		nxt_s.cap_s3 = s_ff.cap_s2;
		nxt_s.xclk_s1 = timer_clock_pin;
		nxt_s.xclk_s2 = s_ff.xclk_s1;
		nxt_s.xclk_s3 = s_ff.xclk_s2;
		nxt_s.ovf_irq = '0;
		nxt_s.evt_irq = '0;
		xrise = {4'h0, s_ff.xclk_s2 & ~s_ff.xclk_s3};
		xfall = {4'h0, ~s_ff.xclk_s2 & s_ff.xclk_s3};
		for (int i = 0; i < ftm_pkg::NCH; i++) begin
			c = s_ff.ch[i];
			tick[i] = s_ff.en[i] && tick_sel(i, c.clk_sel, s_ff.pre, xrise[i], xfall[i]);
			cap_hit[i] = (c.lvl[0] && s_ff.cap_s2[i] && !s_ff.cap_s3[i])
				|| (c.lvl[1] && !s_ff.cap_s2[i] && s_ff.cap_s3[i]);
			if (tick[i]) begin
				if (c.cnt == ftm_pkg::CNT_MAX) begin
					nxt_s.ch[i].cnt = c.rld;
					nxt_s.ch[i].ovf_flag = 1'b1;
					nxt_s.ovf_irq[i] = 1'b1;
				end else begin
					nxt_s.ch[i].cnt = c.cnt + 16'h0001;
				end
			end
			case (c.mode)
				ftm_pkg::MODE_CMO: begin
					if (tick[i] && c.cnt == c.cmp) begin
						nxt_s.ch[i].evt_flag = 1'b1;
						nxt_s.evt_irq[i] = 1'b1;
						case (c.lvl)
							ftm_pkg::LV_LOW: nxt_s.ch[i].out = 1'b0;
							ftm_pkg::LV_HIGH: nxt_s.ch[i].out = 1'b1;
							ftm_pkg::LV_TOGGLE: nxt_s.ch[i].out = ~c.out;
							default: nxt_s.ch[i].out = c.out;
						endcase
					end
				end
				ftm_pkg::MODE_PWM: begin
					if (tick[i] && !c.lvl[1]) begin
						// Recomputed every tick from the new count while level code bit 1 is clear
						nxt_s.ch[i].out = (nxt_s.ch[i].cnt <= c.cmp) ? c.lvl[0] : ~c.lvl[0];
					end
				end
				ftm_pkg::MODE_CAP: begin
					if (cap_hit[i]) begin
						nxt_s.ch[i].cmp = c.cnt;
						nxt_s.ch[i].evt_flag = 1'b1;
						nxt_s.evt_irq[i] = 1'b1;
					end
				end
				default: begin
					// Auto-reload: level code and pin untouched
					nxt_s.ch[i].out = c.out;
				end
			endcase
		end
		// Bus write is applied after the hardware update so it wins, except a status clear of a flag set this cycle
		if (wr_go) begin
			nxt_s.bvalid = 1'b1;
			nxt_s.aw_full = 1'b0;
			nxt_s.w_full = 1'b0;
			nxt_s.bresp = addr_ok(wr_a) ? ftm_pkg::RESP_OKAY : ftm_pkg::RESP_SLVERR;
			if (!addr_ok(wr_a) || !s_ff.w_strb[0]) begin
				nxt_s.bresp = nxt_s.bresp;
			end else if (wr_a == ftm_pkg::OFF_START) begin
				nxt_s.en = s_ff.en | wr_d[5:0];
			end else if (wr_a == ftm_pkg::OFF_STOP) begin
				nxt_s.en = s_ff.en & ~wr_d[5:0];
			end else begin
				case (wr_a[4:0])
					ftm_pkg::OFF_CTRL: begin
						nxt_s.ch[wr_k].mode = wr_d[ftm_pkg::CTRL_MOD_LSB +: 2];
						nxt_s.ch[wr_k].clk_sel = wr_d[ftm_pkg::CTRL_CLK_LSB +: 3];
					end
					ftm_pkg::OFF_STAT: begin
						// A flag set this cycle survives a clear
						nxt_s.ch[wr_k].ovf_flag = nxt_s.ch[wr_k].ovf_flag
							& ~(wr_d[ftm_pkg::STAT_OVF_BIT] & ~nxt_s.ovf_irq[wr_k]);
						nxt_s.ch[wr_k].evt_flag = nxt_s.ch[wr_k].evt_flag
							& ~(wr_d[ftm_pkg::STAT_EVT_BIT] & ~nxt_s.evt_irq[wr_k]);
					end
					ftm_pkg::OFF_CNT: begin
						nxt_s.ch[wr_k].cnt = merge16(s_ff.ch[wr_k].cnt, wr_d[15:0], s_ff.w_strb[1:0]);
						nxt_s.ch[wr_k].rld = merge16(s_ff.ch[wr_k].rld, wr_d[15:0], s_ff.w_strb[1:0]);
					end
					ftm_pkg::OFF_RLD: begin
						nxt_s.ch[wr_k].rld = merge16(s_ff.ch[wr_k].rld, wr_d[15:0], s_ff.w_strb[1:0]);
					end
					ftm_pkg::OFF_CMP: begin
						nxt_s.ch[wr_k].cmp = merge16(s_ff.ch[wr_k].cmp, wr_d[15:0], s_ff.w_strb[1:0]);
					end
					ftm_pkg::OFF_LVL: begin
						nxt_s.ch[wr_k].lvl = wr_d[1:0];
					end
					ftm_pkg::OFF_OUT: begin
						nxt_s.ch[wr_k].out = wr_d[0];
					end
					default: begin
						nxt_s.bresp = ftm_pkg::RESP_OKAY;
					end
				endcase
			end
		end else if (s_ff.bvalid && bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (awvalid && s_ff.awready) begin
			nxt_s.aw_full = 1'b1;
			nxt_s.aw_addr = awaddr;
		end
		if (wvalid && s_ff.wready) begin
			nxt_s.w_full = 1'b1;
			nxt_s.w_data = wdata;
			nxt_s.w_strb = wstrb;
		end
		nxt_s.awready = !nxt_s.aw_full && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.w_full && !nxt_s.bvalid;
		// Read path
		c = s_ff.ch[araddr[7:5] < 3'h6 ? araddr[7:5] : 3'h0];
		if (araddr == ftm_pkg::OFF_START) begin
			rd_word = {26'h0, s_ff.en};
		end else if (araddr == ftm_pkg::OFF_STOP) begin
			rd_word = 32'h0000_0000;
		end else begin
			case (araddr[4:0])
				ftm_pkg::OFF_CTRL: rd_word = {27'h0, c.mode, c.clk_sel};
				ftm_pkg::OFF_STAT: rd_word = {30'h0, c.evt_flag, c.ovf_flag};
				ftm_pkg::OFF_CNT: rd_word = {16'h0, c.cnt};
				ftm_pkg::OFF_RLD: rd_word = {16'h0, c.rld};
				ftm_pkg::OFF_CMP: rd_word = {16'h0, c.cmp};
				ftm_pkg::OFF_LVL: rd_word = {30'h0, c.lvl};
				ftm_pkg::OFF_OUT: rd_word = {31'h0, c.out};
				default: rd_word = 32'h0000_0000;
			endcase
		end
		if (arvalid && s_ff.arready) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata = addr_ok(araddr) ? rd_word : 32'h0000_0000;
			nxt_s.rresp = addr_ok(araddr) ? ftm_pkg::RESP_OKAY : ftm_pkg::RESP_SLVERR;
		end else if (s_ff.rvalid && rready) begin
			nxt_s.rvalid = 1'b0;
		end
		nxt_s.arready = !nxt_s.rvalid;
		for (int i = 0; i < ftm_pkg::NCH; i++) begin
			nxt_s.out_oe[i] = nxt_s.ch[i].mode == ftm_pkg::MODE_CMO
				|| nxt_s.ch[i].mode == ftm_pkg::MODE_PWM;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign awready = s_ff.awready;
	assign wready = s_ff.wready;
	assign bvalid = s_ff.bvalid;
	assign bresp = s_ff.bresp;
	assign arready = s_ff.arready;
	assign rvalid = s_ff.rvalid;
	assign rdata = s_ff.rdata;
	assign rresp = s_ff.rresp;
	assign overflow_irq = s_ff.ovf_irq;
	assign event_irq = s_ff.evt_irq;
	assign timer_output_oe = s_ff.out_oe;
	generate
		for (genvar g = 0; g < ftm_pkg::NCH; g++) begin : g_pin
			assign timer_output_pin[g] = s_ff.ch[g].out;
		end
	endgenerate

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence seq_wrap0;
		s_ff.ch[3].mode == ftm_pkg::MODE_ART && tick[3] && s_ff.ch[3].cnt == ftm_pkg::CNT_MAX && !wr_go;
	endsequence
	sequence seq_cap_rise0;
		s_ff.cap_s2[2] && !s_ff.cap_s3[2];
	endsequence
	sequence seq_cap_mode0;
		s_ff.ch[2].mode == ftm_pkg::MODE_CAP && s_ff.ch[2].lvl == ftm_pkg::CAP_RISE && !wr_go;
	endsequence

	a_start_lockstep: assert property (wr_go && wr_a == ftm_pkg::OFF_START && s_ff.w_strb[0]
		&& wr_d[4] && wr_d[5] |=> s_ff.en[4] && s_ff.en[5]) else $error("start did not enable channels");
	a_stop_halts: assert property (wr_go && wr_a == ftm_pkg::OFF_STOP && s_ff.w_strb[0]
		&& wr_d[4] && wr_d[5] |=> !s_ff.en[4] && !s_ff.en[5] ##1 !tick[4]) else $error("stop did not halt");
	a_art_reload: assert property (seq_wrap0 |=> s_ff.ch[3].cnt == $past(s_ff.ch[3].rld)
		&& overflow_irq[3] && s_ff.ch[3].ovf_flag) else $error("overflow reload wrong");
	a_art_pin_hold: assert property (s_ff.ch[0].mode == ftm_pkg::MODE_ART && !wr_go
		|=> $stable(timer_output_pin[0])) else $error("auto-reload moved pin");
	a_cmo_set_high: assert property (s_ff.ch[0].mode == ftm_pkg::MODE_CMO && s_ff.ch[0].lvl == ftm_pkg::LV_HIGH
		&& tick[0] && s_ff.ch[0].cnt == s_ff.ch[0].cmp && !wr_go |=> timer_output_pin[0] && event_irq[0])
		else $error("compare match wrong");
	a_pwm_level: assert property (s_ff.ch[1].mode == ftm_pkg::MODE_PWM && s_ff.ch[1].lvl == ftm_pkg::LV_LOW
		&& tick[1] && !wr_go |=> timer_output_pin[1] == (s_ff.ch[1].cnt > s_ff.ch[1].cmp))
		else $error("pulse-width level wrong");
	a_cap_copy: assert property ((seq_cap_rise0 and seq_cap_mode0) |=>
		s_ff.ch[2].cmp == $past(s_ff.ch[2].cnt) && event_irq[2] && s_ff.ch[2].evt_flag)
		else $error("capture failed");
	a_sw_out_wins: assert property (wr_go && wr_a == {3'h0, ftm_pkg::OFF_OUT} && s_ff.w_strb[0]
		|=> timer_output_pin[0] == $past(wr_d[0])) else $error("software level lost");
endmodule

// ### sim/pin_partner.sv
`timescale 1ns/1ps
module pin_partner (
	input wire logic aclk,
	input wire logic [5:0] cap_level,
	input wire logic [1:0] ext_run,
	output logic [5:0] capture_input_pin,
	output logic [1:0] timer_clock_pin,
	output int rises
);
	logic [1:0] div_ff;
	initial begin
		capture_input_pin = 6'h00;
		timer_clock_pin = 2'h0;
		rises = 0;
		div_ff = 2'h0;
	end
	// External clock holds each level four cycles and stands still when idle
	always @(posedge aclk) begin
		capture_input_pin <= cap_level;
		div_ff <= div_ff + 2'h1;
		if (div_ff == 2'h3) begin
			timer_clock_pin <= timer_clock_pin ^ ext_run;
			if (ext_run[0] && !timer_clock_pin[0]) begin
				rises <= rises + 1;
			end
		end
	end
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	typedef struct packed {
		logic w;
		logic [7:0] wa;
		logic [31:0] wd;
		logic [7:0] ra;
		logic [31:0] ex;
		logic [1:0] rs;
	} row_t;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic [5:0] cap_level = 6'h00;
	logic [1:0] ext_run = 2'h0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rr;
	logic [31:0] rdata, v, w;
	logic [5:0] capture_input_pin, timer_output_pin, timer_output_oe, overflow_irq, event_irq;
	logic [1:0] timer_clock_pin;
	int bad_count = 0;
	int samples_checked = 0;
	int ncap = 0;
	int rises;
	row_t rows [10];

	flexible_timer flexible_timer_inst (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .capture_input_pin(capture_input_pin),
		.timer_clock_pin(timer_clock_pin), .timer_output_pin(timer_output_pin),
		.timer_output_oe(timer_output_oe), .overflow_irq(overflow_irq), .event_irq(event_irq));
	pin_partner pin_partner_inst (.aclk(aclk), .cap_level(cap_level), .ext_run(ext_run),
		.capture_input_pin(capture_input_pin), .timer_clock_pin(timer_clock_pin), .rises(rises));

	always #20 aclk = ~aclk;
	always @(posedge aclk) begin
		if (event_irq[2] === 1'b1) ncap <= ncap + 1;
	end

	task automatic wrap_up();
		if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		if (n >= 100) bad_count++;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		if (n >= 100) bad_count++;
		v = rdata;
		rr = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wev(input int b, input logic o);
		logic [5:0] s;
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			s = o ? overflow_irq : event_irq;
			n++;
		end while (s[b] !== 1'b1 && n < 5000);
		chk({31'h0, s[b]}, 32'h1);
	endtask
	task automatic compare_output_mode(input logic [1:0] c, input logic i, input logic e);
		wr(8'h14, {30'h0, c});
		wr(8'h18, {31'h0, i});
		wr(8'h08, 32'h0);
		chk({31'h0, timer_output_pin[0]}, {31'h0, i});
		wr(8'hc0, 32'h1);
		wev(0, 1'b0);
		wt(2);
		chk({31'h0, timer_output_pin[0]}, {31'h0, e});
		wr(8'hc4, 32'h1);
		rd(8'h04);
		chk(v, 32'h2);
		wr(8'h04, 32'h3);
	endtask
	task automatic pwm(input logic [1:0] c, input logic [15:0] k, input logic e);
		wr(8'h34, {30'h0, c});
		wr(8'h28, {16'h0, k});
		wr(8'h38, {31'h0, ~e});
		wt(3);
		chk({31'h0, timer_output_pin[1]}, {31'h0, e});
		chk({31'h0, timer_output_oe[1]}, 32'h1);
	endtask

	initial begin
		wt(60000);
		bad_count++;
		wrap_up();
	end

	initial begin
		rows = '{'{1'b0, 8'h00, 32'h0, 8'h14, 32'h0, 2'h0}, '{1'b0, 8'h00, 32'h0, 8'h18, 32'h0, 2'h0},
			'{1'b0, 8'h00, 32'h0, 8'hc0, 32'h0, 2'h0}, '{1'b1, 8'h34, 32'h3, 8'h34, 32'h3, 2'h0},
			'{1'b1, 8'h58, 32'h1, 8'h58, 32'h1, 2'h0}, '{1'b1, 8'hc0, 32'h5, 8'hc0, 32'h5, 2'h0},
			'{1'b1, 8'hc0, 32'h0, 8'hc0, 32'h5, 2'h0}, '{1'b1, 8'hc4, 32'h1, 8'hc0, 32'h4, 2'h0},
			'{1'b1, 8'hc4, 32'h4, 8'hc4, 32'h0, 2'h0}, '{1'b1, 8'he0, 32'hff, 8'he0, 32'h0, 2'h2}};
		wt(3);
		aresetn <= 1'b1;
		wt(2);
		foreach (rows[i]) begin
			if (rows[i].w) wr(rows[i].wa, rows[i].wd);
			rd(rows[i].ra);
			chk(v, rows[i].ex);
			chk({30'h0, rr}, {30'h0, rows[i].rs});
		end
		chk({26'h0, timer_output_pin}, 32'h4);
		wr(8'h00, 32'h08);
		wr(8'h10, 32'h20);
		compare_output_mode(2'h0, 1'b1, 1'b0);
		compare_output_mode(2'h1, 1'b0, 1'b1);
		compare_output_mode(2'h2, 1'b0, 1'b1);
		compare_output_mode(2'h2, 1'b1, 1'b0);
		wr(8'h20, 32'h10);
		wr(8'h30, 32'h8000);
		wr(8'hc0, 32'h2);
		pwm(2'h0, 16'h0000, 1'b0);
		pwm(2'h1, 16'h0000, 1'b1);
		pwm(2'h0, 16'hc000, 1'b1);
		pwm(2'h1, 16'hc000, 1'b0);
		wr(8'hc4, 32'h2);
		wr(8'h40, 32'h18);
		for (int c = 0; c < 4; c++) begin
			wr(8'h54, 32'(c));
			ncap = 0;
			cap_level[2] <= 1'b1;
			wt(8);
			cap_level[2] <= 1'b0;
			wt(8);
			chk(ncap, 32'(c[0]) + 32'(c[1]));
		end
		wr(8'h00, 32'h06);
		wr(8'h08, 32'h0);
		wr(8'hc0, 32'h1);
		ext_run <= 2'h1;
		wt(60);
		ext_run <= 2'h0;
		wt(8);
		wr(8'hc4, 32'h1);
		rd(8'h08);
		chk(v, rises);
		wr(8'h74, 32'h2);
		wr(8'h78, 32'h1);
		wr(8'h68, 32'hfff0);
		wr(8'hc0, 32'h8);
		wev(3, 1'b1);
		chk({31'h0, timer_output_pin[3]}, 32'h1);
		chk({31'h0, timer_output_oe[3]}, 32'h0);
		rd(8'h64);
		chk(v, 32'h1);
		rd(8'h68);
		chk({31'h0, v[15:0] >= 16'hfff0}, 32'h1);
		wr(8'hc4, 32'h8);
		wr(8'h88, 32'h0);
		wr(8'ha8, 32'h0);
		wr(8'hc0, 32'h30);
		wt(20);
		wr(8'hc4, 32'h30);
		rd(8'h88);
		w = v;
		rd(8'ha8);
		chk(v, w);
		wr(8'ha0, 32'h7);
		wr(8'ha8, 32'h0);
		wr(8'hc0, 32'h20);
		wt(1024);
		wr(8'hc4, 32'h20);
		rd(8'ha8);
		chk({31'h0, v inside {32'h8, 32'h9}}, 32'h1);
		aresetn <= 1'b0;
		wt(3);
		aresetn <= 1'b1;
		wt(2);
		rd(8'hc0);
		chk(v, 32'h0);
		chk({26'h0, timer_output_pin}, 32'h0);
		wrap_up();
	end
endmodule
